// ===== fsc_bus_master.sv
/* bus master model issuing register requests to fsc_regs.
   assumes callers enter just after a sys_clk rising edge. */
`timescale 1ns/100ps
`default_nettype none
module fsc_bus_master
   import fsc_pkg::*;
(
   // clock
   input  wire logic     sys_clk,
   // request port
   output var  fsc_req_s req
);
   initial req = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
   // held one edge; back-to-back calls give one request per cycle
   task automatic send(input logic w, input logic [15:0] a, input logic [15:0] d);
      req = '{addr: a, wr: w, rd: ~w, wdata: d};
      @(posedge sys_clk);
      #1;
   endtask
   // released address and data flip, wr and rd clear, so a stale value is never taken for a live one
   task automatic release_bus();
      req = '{addr: ~req.addr, wr: 1'b0, rd: 1'b0, wdata: ~req.wdata};
   endtask
endmodule
`default_nettype wire

// ===== fsc_pkg.sv
/*
 * constants, codes and carriers for the flow setpoint configuration registers.
 * assumes a single 125 MHz clock domain shared with the serial protocol core.
 */
`default_nettype none

package fsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses (zero-based protocol addresses)
   localparam logic [15:0] FSC_ADDR_FLOW_LO     = 16'h000A;
   localparam logic [15:0] FSC_ADDR_FLOW_HI     = 16'h000B;
   localparam logic [15:0] FSC_ADDR_RESERVED    = 16'h0073;
   localparam logic [15:0] FSC_ADDR_CTRL_MODE   = 16'h0074;
   localparam logic [15:0] FSC_ADDR_FLOW_UNIT   = 16'h0075;
   localparam logic [15:0] FSC_ADDR_SP_ORIGIN   = 16'h0076;

   ////////////////////////////////////////////////////////////////////////////
   // encodings
   localparam logic [15:0] FSC_UNIT_M3H         = 16'h0001;
   localparam logic [15:0] FSC_UNIT_LPS         = 16'h0002;
   localparam logic [15:0] FSC_UNIT_CFM         = 16'h0006;
   localparam logic [15:0] FSC_ORIGIN_ANALOG    = 16'h0000;
   localparam logic [15:0] FSC_ORIGIN_BUS       = 16'h0001;
   localparam logic [15:0] FSC_MODE_POSITION    = 16'h0000;
   localparam logic [15:0] FSC_MODE_FLOW        = 16'h0001;
   localparam logic [15:0] FSC_APP_FLOW_CTRL    = 16'h0000;
   localparam logic [15:0] FSC_APP_PRESSURE     = 16'h0001;
   localparam logic [15:0] FSC_APP_ROOM_PRESS   = 16'h0002;
   localparam logic [15:0] FSC_APP_FLOW_MEAS    = 16'h0003;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] FSC_RST_FLOW_UNIT    = 16'h0001;
   localparam logic [15:0] FSC_RST_SP_ORIGIN    = 16'h0001;
   localparam logic [15:0] FSC_RST_ZERO16       = 16'h0000;
   localparam logic [31:0] FSC_RST_ZERO32       = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // fixed-point factors, q16: m3/h to l/s is 1/3.6, m3/h to cfm is 0.58956
   localparam logic [15:0] FSC_K_LPS_Q16        = 16'h471C;
   localparam logic [15:0] FSC_K_CFM_Q16        = 16'h96ED;
   localparam logic [15:0] FSC_K_ONE_SHIFT      = 16'h0010;
   // min/max limits are in 0.01 %, so full scale is 10000
   localparam logic [47:0] FSC_PCT_FULL         = 48'h0000_0000_2710;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } fsc_req_s;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } fsc_rsp_s;

   typedef struct packed {
      logic [15:0] min_pct;
      logic [15:0] max_pct;
   } fsc_limits_s;

endpackage

`default_nettype wire

// ===== fsc_regs.sv
/*
 * flow setpoint configuration register slice: control mode report, flow unit
 * selector, setpoint origin selector, plus the derived limits, flow reading
 * and active setpoint that these registers steer.
 * assumes a protocol core on the same clock presents one request per cycle at
 * most and reads answers one cycle later; all inputs are on sys_clk.
 */
// What this block does
// - control mode reads back read-only: 0 position control, 1 flow control
// - control mode only meaningful while application selection is flow control (0)
// - position mode: min/max limits scale the adapted mechanical travel
// - flow mode: min/max limits scale the nominal flow in cubic metres per hour
// - flow unit selector read/write: 1 m3/h, 2 l/s, 6 cfm; resets to 1
// - absolute flow reading in registers 11/12 uses the selected unit
// - setpoint origin selector read/write, analog or bus; resets to bus
// - origin 0 makes the analog setpoint (register 13) active
// - origin 1 makes the bus setpoint (register 1) active
// - application selection is an input, not a readable register: 0 flow, 1 pressure, 2 room, 3 measurement
`timescale 1ns/100ps
`default_nettype none

module fsc_regs
   import fsc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // register access from the protocol core
   input  wire fsc_req_s    req,
   output var  fsc_rsp_s    rsp,
   // maker configuration and live values
   input  wire logic [15:0] app_select,
   input  wire logic        maker_flow_mode,
   input  wire fsc_limits_s limits,
   input  wire logic [31:0] adapted_travel,
   input  wire logic [31:0] nominal_flow_m3h,
   input  wire logic [31:0] flow_m3h,
   input  wire logic [15:0] setpoint_analog,
   input  wire logic [15:0] setpoint_bus,
   // derived outputs
   output logic      [15:0] active_setpoint,
   output logic      [31:0] limit_min_abs,
   output logic      [31:0] limit_max_abs,
   output logic             flow_mode_active
);

   ////////////////////////////////////////////////////////////////////////////
   // stored state
   logic [15:0] flow_unit_reg;
   logic [15:0] sp_origin_reg;
   logic [31:0] flow_sel_reg;
   fsc_rsp_s    rsp_reg;
   logic [15:0] active_sp_reg;
   logic [31:0] lim_min_reg;
   logic [31:0] lim_max_reg;
   logic        flow_mode_reg;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic hit_flow_lo  = (req.addr == FSC_ADDR_FLOW_LO);
   wire logic hit_flow_hi  = (req.addr == FSC_ADDR_FLOW_HI);
   wire logic hit_rsvd     = (req.addr == FSC_ADDR_RESERVED);
   wire logic hit_mode     = (req.addr == FSC_ADDR_CTRL_MODE);
   wire logic hit_unit     = (req.addr == FSC_ADDR_FLOW_UNIT);
   wire logic hit_origin   = (req.addr == FSC_ADDR_SP_ORIGIN);
   wire logic hit_any      = hit_flow_lo | hit_flow_hi | hit_rsvd | hit_mode | hit_unit | hit_origin;
   wire logic access       = req.wr | req.rd;

   // unassigned unit codes are refused so the reading always has a defined unit
   wire logic unit_code_ok = (req.wdata == FSC_UNIT_M3H) | (req.wdata == FSC_UNIT_LPS)
                             | (req.wdata == FSC_UNIT_CFM);
   wire logic origin_ok    = (req.wdata == FSC_ORIGIN_ANALOG) | (req.wdata == FSC_ORIGIN_BUS);
   wire logic wr_unit      = req.wr & hit_unit & unit_code_ok;
   wire logic wr_origin    = req.wr & hit_origin & origin_ok;
   // flow readings are read-only; control mode and reserved slot drop writes
   wire logic wr_refused   = req.wr & (hit_mode | hit_rsvd | hit_flow_lo | hit_flow_hi);
   wire logic bad_value    = req.wr & ((hit_unit & ~unit_code_ok) | (hit_origin & ~origin_ok));

   ////////////////////////////////////////////////////////////////////////////
   // control mode reads flow only while application selection is flow control and maker_flow_mode is set
   wire logic app_is_flow  = (app_select == FSC_APP_FLOW_CTRL);
   wire logic mode_flow    = app_is_flow & maker_flow_mode;
   wire logic [15:0] mode_view = mode_flow ? FSC_MODE_FLOW : FSC_MODE_POSITION;

   ////////////////////////////////////////////////////////////////////////////
   // flow reading in the selected unit
   logic [31:0] flow_lps;
   logic [31:0] flow_cfm;

   fsc_q16_scale #(
      .VAL_W (32),
      .K_W   (16)
   ) u_to_lps (
      .value  (flow_m3h),
      .factor (FSC_K_LPS_Q16),
      .scaled (flow_lps)
   );

   fsc_q16_scale #(
      .VAL_W (32),
      .K_W   (16)
   ) u_to_cfm (
      .value  (flow_m3h),
      .factor (FSC_K_CFM_Q16),
      .scaled (flow_cfm)
   );

   wire logic [31:0] flow_sel_next = (flow_unit_reg == FSC_UNIT_LPS) ? flow_lps
                                   : (flow_unit_reg == FSC_UNIT_CFM) ? flow_cfm
                                   : flow_m3h;

   ////////////////////////////////////////////////////////////////////////////
   // limits: travel in position mode, nominal flow in flow mode
   wire logic [31:0] limit_base  = mode_flow ? nominal_flow_m3h : adapted_travel;
   logic [31:0] lim_min_next;
   logic [31:0] lim_max_next;

   fsc_pct_scale #(
      .BASE_W (32),
      .PCT_W  (16)
   ) u_lim_min (
      .base   (limit_base),
      .pct    (limits.min_pct),
      .scaled (lim_min_next)
   );

   fsc_pct_scale #(
      .BASE_W (32),
      .PCT_W  (16)
   ) u_lim_max (
      .base   (limit_base),
      .pct    (limits.max_pct),
      .scaled (lim_max_next)
   );

   ////////////////////////////////////////////////////////////////////////////
   // active setpoint; the watchdog on bus renewal lives outside this slice
   wire logic [15:0] active_sp_next = (sp_origin_reg == FSC_ORIGIN_ANALOG) ? setpoint_analog
                                    : setpoint_bus;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [15:0] rdata_next  = ~req.rd     ? FSC_RST_ZERO16
                                 : hit_flow_lo ? flow_sel_reg[15:0]
                                 : hit_flow_hi ? flow_sel_reg[31:16]
                                 : hit_mode    ? mode_view
                                 : hit_unit    ? flow_unit_reg
                                 : hit_origin  ? sp_origin_reg
                                 : FSC_RST_ZERO16;
   wire logic     err_unmapped = access & ~hit_any;
   wire logic     err_write    = req.wr & (wr_refused | bad_value);
   wire fsc_rsp_s rsp_next     = '{ack:   access,
                                   err:   err_unmapped | err_write,
                                   rdata: rdata_next};

   ////////////////////////////////////////////////////////////////////////////
   // selectors take their reset values and drop refused writes
   fsc_sel_reg #(
      .W       (16),
      .RST_VAL (FSC_RST_FLOW_UNIT)
   ) u_unit (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .load    (wr_unit),
      .din     (req.wdata),
      .q       (flow_unit_reg)
   );

   fsc_sel_reg #(
      .W       (16),
      .RST_VAL (FSC_RST_SP_ORIGIN)
   ) u_origin (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .load    (wr_origin),
      .din     (req.wdata),
      .q       (sp_origin_reg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // answer to the protocol core, one edge after the request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live views, one edge behind their inputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flow_sel_reg <= FSC_RST_ZERO32;
      end else begin
         flow_sel_reg <= flow_sel_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         active_sp_reg <= FSC_RST_ZERO16;
      end else begin
         active_sp_reg <= active_sp_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lim_min_reg <= FSC_RST_ZERO32;
      end else begin
         lim_min_reg <= lim_min_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lim_max_reg <= FSC_RST_ZERO32;
      end else begin
         lim_max_reg <= lim_max_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flow_mode_reg <= 1'b0;
      end else begin
         flow_mode_reg <= mode_flow;
      end
   end

   assign rsp              = rsp_reg;
   assign active_setpoint  = active_sp_reg;
   assign limit_min_abs    = lim_min_reg;
   assign limit_max_abs    = lim_max_reg;
   assign flow_mode_active = flow_mode_reg;

endmodule

////////////////////////////////////////////////////////////////////////////////
// value times a q16 factor, fraction dropped
module fsc_q16_scale
   import fsc_pkg::*;
#(
   parameter int VAL_W = 32,
   parameter int K_W   = 16
) (
   // operands
   input  wire logic [VAL_W-1:0] value,
   input  wire logic [K_W-1:0]   factor,
   // result
   output logic      [VAL_W-1:0] scaled
);

   // full-width product so no integer bits are lost before the cut
   wire logic [VAL_W+K_W-1:0] product = value * factor;

   assign scaled = product[VAL_W+K_W-1:K_W];

endmodule

////////////////////////////////////////////////////////////////////////////////
// base times a limit in 0.01 %, truncated
module fsc_pct_scale
   import fsc_pkg::*;
#(
   parameter int BASE_W = 32,
   parameter int PCT_W  = 16
) (
   // operands
   input  wire logic [BASE_W-1:0] base,
   input  wire logic [PCT_W-1:0]  pct,
   // result
   output logic      [BASE_W-1:0] scaled
);

   // constant divisor keeps this fixed logic, but it is the deepest path here
   wire logic [BASE_W+PCT_W-1:0] product  = base * pct;
   wire logic [BASE_W+PCT_W-1:0] quotient = product / FSC_PCT_FULL;

   assign scaled = quotient[BASE_W-1:0];

endmodule

////////////////////////////////////////////////////////////////////////////////
// selector register: loads only on an accepted write
module fsc_sel_reg
   import fsc_pkg::*;
#(
   parameter int           W       = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   // load
   input  wire logic         load,
   input  wire logic [W-1:0] din,
   // stored value
   output logic      [W-1:0] q
);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= RST_VAL;
      end else if (load) begin
         q <= din;
      end
   end

endmodule

`default_nettype wire

// ===== fsc_regs_monitor.sv
/* checker for the fsc_regs request/answer port and the active setpoint and flow mode outputs.
   assumes it is bound onto fsc_regs; one sys_clk domain, nrst async low. */
`timescale 1ns/100ps
`default_nettype none
module fsc_regs_monitor
   import fsc_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // watched ports
   input wire fsc_req_s    req,
   input wire fsc_rsp_s    rsp,
   input wire logic [15:0] setpoint_analog,
   input wire logic [15:0] setpoint_bus,
   input wire logic [15:0] active_setpoint,
   input wire logic        flow_mode_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire req_any = req.wr | req.rd;
   property p_ack; req_any |=> rsp.ack; endproperty
   a_ack: assert property (p_ack) else $error("no answer after request");
   property p_idle; !req_any |=> !rsp.ack; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_mode; req.rd && req.addr == FSC_ADDR_CTRL_MODE |=> rsp.rdata == {15'h0000, flow_mode_active}; endproperty
   a_mode: assert property (p_mode) else $error("control mode read wrong");
   property p_ro; req.wr && (req.addr == FSC_ADDR_CTRL_MODE || req.addr == FSC_ADDR_RESERVED) |=> rsp.err; endproperty
   a_ro: assert property (p_ro) else $error("read-only write accepted");
   property p_rsvd; req.rd && req.addr == FSC_ADDR_RESERVED |=> rsp.rdata == 16'h0000 && !rsp.err; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
   property p_unit; req.rd && req.addr == FSC_ADDR_FLOW_UNIT |=> rsp.rdata inside {16'h0001, 16'h0002, 16'h0006}; endproperty
   a_unit: assert property (p_unit) else $error("unit holds unassigned code");
   property p_ubad; req.wr && req.addr == FSC_ADDR_FLOW_UNIT && !(req.wdata inside {16'h0001, 16'h0002, 16'h0006})
      |=> rsp.err; endproperty
   a_ubad: assert property (p_ubad) else $error("bad unit code accepted");
   property p_orig; req.rd && req.addr == FSC_ADDR_SP_ORIGIN |=> rsp.rdata <= FSC_ORIGIN_BUS; endproperty
   a_orig: assert property (p_orig) else $error("origin out of range");
   property p_sp; 1'b1 |=> active_setpoint == $past(setpoint_analog) || active_setpoint == $past(setpoint_bus); endproperty
   a_sp: assert property (p_sp) else $error("active setpoint from neither source");
endmodule
bind fsc_regs fsc_regs_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rsp(rsp),
   .setpoint_analog(setpoint_analog), .setpoint_bus(setpoint_bus), .active_setpoint(active_setpoint),
   .flow_mode_active(flow_mode_active));
`default_nettype wire

// ===== fsc_regs_tb_top.sv
/* self-checking bench for fsc_regs: answers are compared in order against
   queued expectations. assumes the package, master model and checker first. */
`timescale 1ns/100ps
`default_nettype none
module fsc_regs_tb_top
   import fsc_pkg::*;
();
   logic        sys_clk, nrst, maker_flow_mode, flow_mode_active;
   logic [15:0] app_select, setpoint_analog, setpoint_bus, active_setpoint, u;
   logic [31:0] adapted_travel, nominal_flow_m3h, flow_m3h, limit_min_abs, limit_max_abs, f;
   logic [63:0] e;
   fsc_req_s    req;
   fsc_rsp_s    rsp;
   fsc_limits_s limits;
   logic [16:0] exp_q[$];
   integer      seed = 32'heae0_07f5, err_total = 0, comparisons = 0, i;
   fsc_bus_master BFM (.sys_clk(sys_clk), .req(req));
   fsc_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rsp(rsp), .app_select(app_select),
      .maker_flow_mode(maker_flow_mode), .limits(limits), .adapted_travel(adapted_travel),
      .nominal_flow_m3h(nominal_flow_m3h), .flow_m3h(flow_m3h), .setpoint_analog(setpoint_analog),
      .setpoint_bus(setpoint_bus), .active_setpoint(active_setpoint), .limit_min_abs(limit_min_abs),
      .limit_max_abs(limit_max_abs), .flow_mode_active(flow_mode_active));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // expectation is queued before the request so the answer always finds it
   task automatic rq(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [16:0] x);
      exp_q.push_back(x);
      BFM.send(w, a, d);
   endtask
   task automatic tick(input int n);
      BFM.release_bus();
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   always begin
      @(posedge sys_clk);
      #2;
      if (rsp.ack === 1'b1 && exp_q.size() == 0) begin
         chk(32'h0000_0001, 32'h0000_0000);
      end else if (rsp.ack === 1'b1) begin
         chk({15'h0000, rsp.err, rsp.rdata}, {15'h0000, exp_q.pop_front()});
      end
   end
   initial begin
      #200_000;
      err_total++;
      finish_test();
   end
   initial begin
      nrst = 1'b0;
      {app_select, maker_flow_mode, limits, adapted_travel, nominal_flow_m3h, flow_m3h} = '0;
      setpoint_analog = 16'h1111;
      setpoint_bus = 16'h2222;
      repeat (12) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      tick(1);
      rq(1'b0, FSC_ADDR_FLOW_UNIT, 16'h0000, {1'b0, FSC_RST_FLOW_UNIT});
      rq(1'b0, FSC_ADDR_SP_ORIGIN, 16'h0000, {1'b0, FSC_RST_SP_ORIGIN});
      u = FSC_UNIT_M3H;
      for (i = 0; i < 7; i++) begin
         if (i == 1 || i == 2 || i == 6) u = 16'(i);
         rq(1'b1, FSC_ADDR_FLOW_UNIT, 16'(i), {!(i == 1 || i == 2 || i == 6), 16'h0000});
         rq(1'b0, FSC_ADDR_FLOW_UNIT, 16'h0000, {1'b0, u});
      end
      for (i = 0; i < 3; i++) begin
         f = $random(seed) & 32'h00FF_FFFF;
         flow_m3h = f;
         rq(1'b1, FSC_ADDR_FLOW_UNIT, (i == 0) ? FSC_UNIT_M3H : (i == 1) ? FSC_UNIT_LPS : FSC_UNIT_CFM, 17'h0_0000);
         tick(2);
         e = (i == 0) ? f : (f * ((i == 1) ? FSC_K_LPS_Q16 : FSC_K_CFM_Q16)) >> FSC_K_ONE_SHIFT;
         rq(1'b0, FSC_ADDR_FLOW_LO, 16'h0000, {1'b0, e[15:0]});
         rq(1'b0, FSC_ADDR_FLOW_HI, 16'h0000, {1'b0, e[31:16]});
      end
      for (i = 0; i < 8; i++) begin
         app_select = 16'(i >> 1);
         maker_flow_mode = i[0];
         limits = {16'($unsigned($random(seed)) % 10001), 16'h2710};
         adapted_travel = $random(seed);
         nominal_flow_m3h = $random(seed);
         tick(2);
         e = (i == 1) ? nominal_flow_m3h : adapted_travel;
         chk(32'(flow_mode_active), 32'(i == 1));
         chk(limit_min_abs, 32'(e * limits.min_pct / 10000));
         chk(limit_max_abs, e[31:0]);
         rq(1'b0, FSC_ADDR_CTRL_MODE, 16'h0000, {16'h0000, i == 1});
      end
      rq(1'b1, FSC_ADDR_CTRL_MODE, 16'h0001, 17'h1_0000);
      rq(1'b1, FSC_ADDR_RESERVED, 16'hFFFF, 17'h1_0000);
      rq(1'b0, FSC_ADDR_RESERVED, 16'h0000, 17'h0_0000);
      rq(1'b0, 16'h0050, 16'h0000, 17'h1_0000);
      for (i = 0; i < 3; i++) begin
         setpoint_analog = 16'($random(seed));
         setpoint_bus = 16'($random(seed));
         rq(1'b1, FSC_ADDR_SP_ORIGIN, 16'(i ^ (i >> 1)), {i == 2, 16'h0000});
         tick(2);
         chk(32'(active_setpoint), 32'((i == 0) ? setpoint_analog : setpoint_bus));
      end
      tick(3);
      chk(32'(exp_q.size()), 32'h0000_0000);
      finish_test();
   end
endmodule
`default_nettype wire
